// file: hdl/spcr_pkg.sv
package spcr_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_MSI_CTRL   = 8'h4C;
    localparam logic [7:0] OFF_MSI_ADDR   = 8'h50;
    localparam logic [7:0] OFF_MSI_UPPER  = 8'h54;
    localparam logic [7:0] OFF_MSI_DATA   = 8'h58;
    localparam logic [7:0] OFF_PD_CTRL    = 8'h5C;
    localparam logic [7:0] OFF_PD_WORD    = 8'h60;
    localparam logic [7:0] OFF_VEND_HDR   = 8'h64;
    localparam logic [7:0] OFF_TEST0      = 8'h68;
    localparam logic [7:0] OFF_TEST1      = 8'h6C;
    localparam logic [7:0] OFF_TIMERS     = 8'h70;
    // capability header constants
    localparam logic [7:0]  PD_CAP_ID     = 8'h03;
    localparam logic [7:0]  PD_NEXT_PTR   = 8'h64;
    localparam logic [7:0]  VEND_CAP_ID   = 8'h09;
    localparam logic [7:0]  VEND_NEXT_PTR = 8'hB0;
    localparam logic [15:0] VEND_LENGTH   = 16'h0034;
    localparam logic [7:0]  MSI_CAP_ID    = 8'h05;
    // field positions
    localparam int PD_ADDR_LSB  = 18;
    localparam int PD_ADDR_MSB  = 23;
    localparam int PD_OP_BIT    = 31;
    localparam int MSI_EN_BIT   = 16;
    localparam int MSI_64_BIT   = 23;
    localparam int REPLAY_EN    = 12;
    localparam int PM_DIS_BIT   = 13;
    localparam int MSI_DIS_BIT  = 14;
    localparam int ACK_LSB      = 16;
    localparam int ACK_MSB      = 29;
    localparam int ACK_EN       = 30;
    localparam int VGA_BIT      = 31;
    // reset values
    localparam logic [31:0] TEST0_RST  = 32'h0400_1060;
    localparam logic [31:0] TEST1_RST  = 32'h0400_0800;
    localparam logic [31:0] ZERO_RST   = 32'h0000_0000;
    localparam logic [5:0]  TABLE_ADDR_RST = 6'h00;
    localparam int TABLE_DEPTH = 64;
    // product data table access sequencer states
    typedef enum logic [1:0] {SPCR_IDLE, SPCR_RD, SPCR_RDDONE, SPCR_WR} spcr_state_e;
endpackage

// file: hdl/spcr_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// port between the access sequencer and the product data table
interface spcr_mem_if;
    logic        we;    // write strobe
    logic        re;    // read strobe
    logic [5:0]  addr;  // doubleword index
    logic [31:0] wdata; // word to store
    logic [31:0] rdata; // registered read word
    modport ctl (output we, re, addr, wdata, input rdata);
    modport mem (input we, re, addr, wdata, output rdata);
endinterface
`default_nettype wire

// file: hdl/spcr_table_mem.sv
`timescale 1ns/1ps
`default_nettype none
// product data table store, registered read data
module spcr_table_mem (
    input  wire logic   clk,
    spcr_mem_if.mem     port
);
    logic [31:0] mem_q [spcr_pkg::TABLE_DEPTH]; // table words
    logic [31:0] rdata_q;                        // read register

    // write port
    always_ff @(posedge clk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge clk) begin
        if (port.re) begin
            rdata_q <= mem_q[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// file: hdl/spcr_regs.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R01) upper address used only when 64-bit capable
// (R02) 64-bit capable bit reads one, read-only
// (R03) lower address is dword-aligned interrupt target
// (R04) product data capability id reads 03h
// (R05) product data next pointer reads 64h
// (R06) 6-bit table address, writable, resets zero
// (R07) flag zero: read, sets one when done
// (R08) flag one: write, clears zero when done
// (R09) data register returns last fetched word
// (R10) data register written is stored word
// (R11) vendor capability id reads 09h
// (R12) vendor next pointer reads B0h
// (R13) vendor length reads 0034h, read-only
// (R14) two test words with given resets
// (R15) 12-bit user replay value, resets zero
// (R16) replay enable selects user replay value
// (R17) 14-bit user ack latency, resets zero
// (R18) ack enable selects user ack latency
// (R19) legacy video decode bit reads one
// (R20) defaults reloadable from eeprom or smbus
// (R21) data updated before read completion flagged
module spcr_regs (
    input  wire logic        CLK,              // 200 MHz clock
    input  wire logic        RST,              // async reset, high
    input  wire logic [7:0]  ADDR,             // register byte address
    input  wire logic [31:0] WDATA,            // write data
    input  wire logic        WR,               // write strobe
    input  wire logic        RD,               // read strobe
    output logic      [31:0] RDATA,            // read data, cycle after RD
    input  wire logic        DEF_LOAD,         // default reload pulse
    input  wire logic [31:0] DEF_TIMERS,       // reload value for timer word
    input  wire logic        MSI_REQ,          // interrupt write request pulse
    output logic             MSI_VALID,        // interrupt write issued
    output logic      [63:0] MSI_ADDR,         // interrupt write address
    output logic      [31:0] MSI_WDATA,        // interrupt write data
    input  wire logic [11:0] REPLAY_BUILTIN,   // link default replay value
    input  wire logic [13:0] ACK_BUILTIN,      // link default ack latency
    output logic      [11:0] REPLAY_LIMIT,     // replay value in use
    output logic      [13:0] ACK_LIMIT,        // ack latency in use
    output logic             VGA_DECODE,       // legacy video decode enable
    output logic             PD_BUSY           // table cycle in progress
);
    logic [31:0] msi_upper_q;   // upper message address
    logic [29:0] msi_lower_q;   // lower message address, dword
    logic [15:0] msi_data_q;    // message data
    logic        msi_en_q;      // message interrupt enable
    logic [2:0]  msi_mme_q;     // multiple message enable
    logic [5:0]  pd_addr_q;     // table dword address
    logic        pd_op_q;       // operation flag
    logic [31:0] pd_word_q;     // product data word
    logic [31:0] test0_q;       // test word 0
    logic [31:0] test1_q;       // test word 1
    logic [11:0] replay_q;      // user replay value
    logic        replay_en_q;   // replay override enable
    logic        pm_dis_q;      // power capability disable
    logic        msi_dis_q;     // message capability disable
    logic [13:0] ack_q;         // user ack latency
    logic        ack_en_q;      // ack override enable
    logic        vga_q;         // legacy video decode
    logic [31:0] rdata_q;       // read data register
    logic        msi_valid_q;   // issued interrupt strobe
    logic [63:0] msi_addr_q;    // issued address
    logic [31:0] msi_wdata_q;   // issued data
    spcr_pkg::spcr_state_e state_q; // table sequencer

    spcr_mem_if mem ();         // table port

    // write decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic wr_pd_ctrl;           // control word write
    assign wr_pd_ctrl = WR && hit(ADDR, spcr_pkg::OFF_PD_CTRL);
    logic seq_idle;             // sequencer ready for a new cycle
    assign seq_idle = (state_q == spcr_pkg::SPCR_IDLE);

    // message interrupt registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            msi_upper_q <= spcr_pkg::ZERO_RST;
            msi_lower_q <= 30'h0000_0000;
            msi_data_q  <= 16'h0000;
            msi_en_q    <= 1'b0;
            msi_mme_q   <= 3'h0;
        end else if (WR) begin
            if (hit(ADDR, spcr_pkg::OFF_MSI_CTRL)) begin
                msi_en_q  <= WDATA[spcr_pkg::MSI_EN_BIT];
                msi_mme_q <= WDATA[22:20];
            end
            if (hit(ADDR, spcr_pkg::OFF_MSI_ADDR)) begin
                msi_lower_q <= WDATA[31:2];
            end
            if (hit(ADDR, spcr_pkg::OFF_MSI_UPPER)) begin
                msi_upper_q <= WDATA;
            end
            if (hit(ADDR, spcr_pkg::OFF_MSI_DATA)) begin
                msi_data_q <= WDATA[15:0];
            end
        end
    end

    // interrupt memory write generation
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            msi_valid_q <= 1'b0;
            msi_addr_q  <= 64'h0;
            msi_wdata_q <= spcr_pkg::ZERO_RST;
        end else begin
            msi_valid_q <= MSI_REQ && msi_en_q && !msi_dis_q;
            if (MSI_REQ && msi_en_q && !msi_dis_q) begin
                // 64-bit capability is hardwired set, so upper half applies [R01] [R02]
                msi_addr_q  <= {msi_upper_q, msi_lower_q, 2'b00}; // [R03]
                msi_wdata_q <= {16'h0000, msi_data_q};
            end
        end
    end

    // table address and operation flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pd_addr_q <= spcr_pkg::TABLE_ADDR_RST;
            pd_op_q   <= 1'b0;
        end else if (wr_pd_ctrl && seq_idle) begin
            pd_addr_q <= WDATA[spcr_pkg::PD_ADDR_MSB:spcr_pkg::PD_ADDR_LSB]; // [R06]
            pd_op_q   <= WDATA[spcr_pkg::PD_OP_BIT];
        end else if (state_q == spcr_pkg::SPCR_RDDONE) begin
            pd_op_q <= 1'b1; // read finished [R07]
        end else if (state_q == spcr_pkg::SPCR_WR) begin
            pd_op_q <= 1'b0; // write finished [R08]
        end
    end

    // table cycle sequencer; control writes during a cycle are ignored
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= spcr_pkg::SPCR_IDLE;
        end else begin
            case (state_q)
                spcr_pkg::SPCR_IDLE: begin
                    if (wr_pd_ctrl) begin
                        state_q <= WDATA[spcr_pkg::PD_OP_BIT] ?
                                   spcr_pkg::SPCR_WR : spcr_pkg::SPCR_RD; // [R07] [R08]
                    end
                end
                spcr_pkg::SPCR_RD:     state_q <= spcr_pkg::SPCR_RDDONE;
                spcr_pkg::SPCR_RDDONE: state_q <= spcr_pkg::SPCR_IDLE;
                spcr_pkg::SPCR_WR:     state_q <= spcr_pkg::SPCR_IDLE;
                default:               state_q <= spcr_pkg::SPCR_IDLE;
            endcase
        end
    end

    // table port drive
    assign mem.re    = (state_q == spcr_pkg::SPCR_RD);
    assign mem.we    = (state_q == spcr_pkg::SPCR_WR); // [R10]
    assign mem.addr  = pd_addr_q;
    assign mem.wdata = pd_word_q;

    spcr_table_mem u_table (
        .clk  (CLK),
        .port (mem)
    );

    // product data word: software write or fetched word
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pd_word_q <= spcr_pkg::ZERO_RST; // [R10]
        end else if (state_q == spcr_pkg::SPCR_RDDONE) begin
            pd_word_q <= mem.rdata; // same edge as flag set [R09] [R21]
        end else if (WR && hit(ADDR, spcr_pkg::OFF_PD_WORD) && seq_idle) begin
            pd_word_q <= WDATA;
        end
    end

    // test words
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            test0_q <= spcr_pkg::TEST0_RST; // [R14]
            test1_q <= spcr_pkg::TEST1_RST; // [R14]
        end else if (WR) begin
            if (hit(ADDR, spcr_pkg::OFF_TEST0)) begin
                test0_q <= WDATA;
            end
            if (hit(ADDR, spcr_pkg::OFF_TEST1)) begin
                test1_q <= WDATA;
            end
        end
    end

    // timer overrides, reloadable defaults
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            replay_q    <= 12'h000;
            replay_en_q <= 1'b0;
            pm_dis_q    <= 1'b0;
            msi_dis_q   <= 1'b0;
            ack_q       <= 14'h0000;
            ack_en_q    <= 1'b0;
            vga_q       <= 1'b1; // [R19]
        end else if (DEF_LOAD) begin
            replay_q    <= DEF_TIMERS[11:0]; // [R20]
            replay_en_q <= DEF_TIMERS[spcr_pkg::REPLAY_EN];
            pm_dis_q    <= DEF_TIMERS[spcr_pkg::PM_DIS_BIT];
            msi_dis_q   <= DEF_TIMERS[spcr_pkg::MSI_DIS_BIT];
            ack_q       <= DEF_TIMERS[spcr_pkg::ACK_MSB:spcr_pkg::ACK_LSB];
            ack_en_q    <= DEF_TIMERS[spcr_pkg::ACK_EN];
        end else if (WR && hit(ADDR, spcr_pkg::OFF_TIMERS)) begin
            replay_q    <= WDATA[11:0]; // [R15]
            replay_en_q <= WDATA[spcr_pkg::REPLAY_EN];
            ack_q       <= WDATA[spcr_pkg::ACK_MSB:spcr_pkg::ACK_LSB]; // [R17]
            ack_en_q    <= WDATA[spcr_pkg::ACK_EN];
        end
    end

    // values in use by the link layer
    assign REPLAY_LIMIT = replay_en_q ? replay_q : REPLAY_BUILTIN; // [R16]
    assign ACK_LIMIT    = ack_en_q ? ack_q : ACK_BUILTIN;          // [R18]
    assign VGA_DECODE   = vga_q;
    assign PD_BUSY      = !seq_idle;
    assign MSI_VALID    = msi_valid_q;
    assign MSI_ADDR     = msi_addr_q;
    assign MSI_WDATA    = msi_wdata_q;

    // read mux, data in the cycle after the strobe
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= spcr_pkg::ZERO_RST;
        end else if (RD) begin
            case (ADDR)
                spcr_pkg::OFF_MSI_CTRL:
                    rdata_q <= {8'h00, 1'b1, msi_mme_q, 3'h0, msi_en_q,
                                spcr_pkg::PD_NEXT_PTR, spcr_pkg::MSI_CAP_ID}; // [R02]
                spcr_pkg::OFF_MSI_ADDR:  rdata_q <= {msi_lower_q, 2'b00};
                spcr_pkg::OFF_MSI_UPPER: rdata_q <= msi_upper_q;
                spcr_pkg::OFF_MSI_DATA:  rdata_q <= {16'h0000, msi_data_q};
                spcr_pkg::OFF_PD_CTRL:
                    rdata_q <= {pd_op_q, 7'h00, pd_addr_q, 2'b00,
                                spcr_pkg::PD_NEXT_PTR, spcr_pkg::PD_CAP_ID}; // [R04] [R05]
                spcr_pkg::OFF_PD_WORD:   rdata_q <= pd_word_q; // [R09]
                spcr_pkg::OFF_VEND_HDR:
                    rdata_q <= {spcr_pkg::VEND_LENGTH, spcr_pkg::VEND_NEXT_PTR,
                                spcr_pkg::VEND_CAP_ID}; // [R11] [R12] [R13]
                spcr_pkg::OFF_TEST0:     rdata_q <= test0_q;
                spcr_pkg::OFF_TEST1:     rdata_q <= test1_q;
                spcr_pkg::OFF_TIMERS:
                    rdata_q <= {vga_q, ack_en_q, ack_q, 1'b0, msi_dis_q,
                                pm_dis_q, replay_en_q, replay_q};
                default:                 rdata_q <= spcr_pkg::ZERO_RST;
            endcase
        end
    end
    assign RDATA = rdata_q;

    // a read request holds the flag at zero until the read completes
    property p_read_flag;
        @(posedge CLK) disable iff (RST)
        (wr_pd_ctrl && seq_idle && !WDATA[31]) |=> !pd_op_q ##1 !pd_op_q ##1 pd_op_q;
    endproperty
    a_read_flag: assert property (p_read_flag) else $error("read flag sequence wrong"); // [R07]

    // a write request holds the flag at one until the write completes
    property p_write_flag;
        @(posedge CLK) disable iff (RST)
        (wr_pd_ctrl && seq_idle && WDATA[31]) |=> pd_op_q ##1 !pd_op_q;
    endproperty
    a_write_flag: assert property (p_write_flag) else $error("write flag sequence wrong"); // [R08]

    // fetched word present when read completion is flagged
    property p_data_first;
        @(posedge CLK) disable iff (RST)
        (state_q == spcr_pkg::SPCR_RDDONE) |=> (pd_word_q == $past(mem.rdata)) && pd_op_q;
    endproperty
    a_data_first: assert property (p_data_first) else $error("data late vs flag"); // [R21]

    // vendor header read returns fixed constants
    property p_vend_hdr;
        @(posedge CLK) disable iff (RST)
        (RD && ADDR == spcr_pkg::OFF_VEND_HDR) |=> RDATA == 32'h0034_B009;
    endproperty
    a_vend_hdr: assert property (p_vend_hdr) else $error("vendor header wrong"); // [R13]

    // product data header low half fixed
    property p_pd_hdr;
        @(posedge CLK) disable iff (RST)
        (RD && ADDR == spcr_pkg::OFF_PD_CTRL) |=> RDATA[15:0] == 16'h6403;
    endproperty
    a_pd_hdr: assert property (p_pd_hdr) else $error("product data header wrong"); // [R04]

    // a timer write picks the user or the built-in replay value
    property p_replay;
        @(posedge CLK) disable iff (RST)
        (WR && ADDR == spcr_pkg::OFF_TIMERS && !DEF_LOAD) |=>
            REPLAY_LIMIT == ($past(WDATA[spcr_pkg::REPLAY_EN]) ? $past(WDATA[11:0])
                                                                : REPLAY_BUILTIN);
    endproperty
    a_replay: assert property (p_replay) else $error("replay value wrong"); // [R15] [R16]

    // a timer write picks the user or the built-in ack latency
    property p_ack;
        @(posedge CLK) disable iff (RST)
        (WR && ADDR == spcr_pkg::OFF_TIMERS && !DEF_LOAD) |=>
            ACK_LIMIT == ($past(WDATA[spcr_pkg::ACK_EN])
                          ? $past(WDATA[spcr_pkg::ACK_MSB:spcr_pkg::ACK_LSB]) : ACK_BUILTIN);
    endproperty
    a_ack: assert property (p_ack) else $error("ack latency wrong"); // [R17] [R18]

    // interrupt address is dword aligned and carries upper half
    property p_msi_addr;
        @(posedge CLK) disable iff (RST)
        MSI_VALID |-> MSI_ADDR[1:0] == 2'b00 && MSI_ADDR[63:32] == $past(msi_upper_q);
    endproperty
    a_msi_addr: assert property (p_msi_addr) else $error("interrupt address wrong"); // [R03]

    // legacy video decode stays set
    property p_vga;
        @(posedge CLK) disable iff (RST)
        VGA_DECODE;
    endproperty
    a_vga: assert property (p_vga) else $error("video decode cleared"); // [R19]

    // requests while message interrupts are off issue nothing
    property p_msi_block;
        @(posedge CLK) disable iff (RST)
        (MSI_REQ && !msi_en_q) |=> !MSI_VALID;
    endproperty
    a_msi_block: assert property (p_msi_block) else $error("interrupt issued while off"); // [R03]

    // an accepted control write loads the table address
    property p_addr_load;
        @(posedge CLK) disable iff (RST)
        (wr_pd_ctrl && seq_idle) |=>
            pd_addr_q == $past(WDATA[spcr_pkg::PD_ADDR_MSB:spcr_pkg::PD_ADDR_LSB]);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("table address not loaded"); // [R06]

    // a test word 1 write lands whole
    property p_test_word;
        @(posedge CLK) disable iff (RST)
        (WR && ADDR == spcr_pkg::OFF_TEST1) |=> test1_q == $past(WDATA);
    endproperty
    a_test_word: assert property (p_test_word) else $error("test word not stored"); // [R14]
endmodule
`default_nettype wire

// file: dv/spcr_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// link layer stand-in: built-in timer values out, interrupt writes logged
module spcr_link_model #(
    parameter logic [11:0] REPLAY_DEF = 12'h2A5,  // built-in replay value
    parameter logic [13:0] ACK_DEF    = 14'h0C31  // built-in ack latency
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        msi_valid,
    input  wire logic [63:0] msi_addr,
    input  wire logic [31:0] msi_wdata,
    output logic      [11:0] replay_builtin,
    output logic      [13:0] ack_builtin,
    output logic      [15:0] msi_cnt,
    output logic      [63:0] last_addr,
    output logic      [31:0] last_data
);
    // built-in values stay fixed so overrides are easy to tell apart
    assign replay_builtin = REPLAY_DEF;
    assign ack_builtin    = ACK_DEF;
    // log each interrupt write the port issues
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msi_cnt   <= 16'h0000;
            last_addr <= 64'h0;
            last_data <= 32'h0;
        end else if (msi_valid) begin
            msi_cnt   <= msi_cnt + 16'h0001;
            last_addr <= msi_addr;
            last_data <= msi_wdata;
        end
    end
endmodule
`default_nettype wire

// file: dv/switch_port_capability_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t ns: got %h want %h", $time, (g), (e)); end end
module switch_port_capability_registers_tb;
    logic        clk, rst, bus_wr, bus_rd, def_load, msi_req;  // driven by the bench
    logic [7:0]  addr;                                         // register address
    logic [31:0] wdata, def_timers, rdata, msi_wdata, last_data;
    logic        msi_valid, vga, busy;                         // design flags
    logic [63:0] msi_addr, last_addr;                          // interrupt addresses
    logic [11:0] replay_b, replay_lim;                         // replay values
    logic [13:0] ack_b, ack_lim;                               // ack latency values
    logic [15:0] msi_cnt;                                      // interrupt writes seen
    logic [31:0] rs = 32'h0000_004F;                           // xorshift state
    logic [31:0] v, la, ua, md, td [8];                        // scenario values
    logic [5:0]  ta [8];                                       // table addresses
    logic [7:0]  ra [10];                                      // reset check addresses
    logic [31:0] rv [10];                                      // reset check values
    int          err_count = 0, cmp_count = 0;

    spcr_regs i_spcr_regs (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(bus_wr),
        .RD(bus_rd), .RDATA(rdata), .DEF_LOAD(def_load), .DEF_TIMERS(def_timers),
        .MSI_REQ(msi_req), .MSI_VALID(msi_valid), .MSI_ADDR(msi_addr), .MSI_WDATA(msi_wdata),
        .REPLAY_BUILTIN(replay_b), .ACK_BUILTIN(ack_b), .REPLAY_LIMIT(replay_lim),
        .ACK_LIMIT(ack_lim), .VGA_DECODE(vga), .PD_BUSY(busy));
    spcr_link_model i_spcr_link_model (.clk(clk), .rst(rst), .msi_valid(msi_valid),
        .msi_addr(msi_addr), .msi_wdata(msi_wdata), .replay_builtin(replay_b),
        .ack_builtin(ack_b), .msi_cnt(msi_cnt), .last_addr(last_addr), .last_data(last_data));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // xorshift source, seeded at 79
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // timer word after a software write: only writable fields change
    function automatic logic [31:0] tmr_wr(input logic [31:0] d);
        return (d & 32'h7FFF_1FFF) | 32'h8000_0000;
    endfunction
    // timer word after a default reload: disable bits follow too
    function automatic logic [31:0] tmr_def(input logic [31:0] d);
        return (d & 32'h7FFF_7FFF) | 32'h8000_0000;
    endfunction
    // product data control word as read back
    function automatic logic [31:0] pd_ctl(input logic op, input logic [5:0] a);
        return {op, 7'h00, a, 2'b00, 16'h6403};
    endfunction

    // one write cycle; a gap cycle comes first so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    // one read cycle, may follow a write with no gap
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        `CHK(rdata, e)
        @(posedge clk);
    endtask
    // bounded wait for the table cycle to end
    task automatic wait_idle();
        #1;
        for (int k = 0; k < 16 && busy !== 1'b0; k++) @(negedge clk);
        `CHK(busy, 1'b0)
        @(posedge clk);
    endtask
    // interrupt request pulse, answer checked in the following cycle
    task automatic msi_pulse(input logic en);
        @(posedge clk);
        msi_req <= 1'b1;
        @(posedge clk);
        msi_req <= 1'b0;
        #1;
        `CHK(msi_valid, en)
        if (en) `CHK(msi_addr, {ua, la[31:2], 2'b00})
        if (en) `CHK(msi_wdata, {16'h0000, md[15:0]})
        @(posedge clk);
    endtask
    // counts and verdict, the single end of the run
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #300000;
        err_count++;
        summarize();
    end

    // main sequence
    initial begin
        clk = 1'b0; rst = 1'b1; addr = 8'h00; wdata = 32'h0; bus_wr = 1'b0; bus_rd = 1'b0;
        def_load = 1'b0; def_timers = 32'h0; msi_req = 1'b0;
        ra = '{spcr_pkg::OFF_MSI_CTRL, spcr_pkg::OFF_MSI_ADDR, spcr_pkg::OFF_MSI_UPPER,
               spcr_pkg::OFF_MSI_DATA, spcr_pkg::OFF_PD_CTRL, spcr_pkg::OFF_PD_WORD,
               spcr_pkg::OFF_VEND_HDR, spcr_pkg::OFF_TEST0, spcr_pkg::OFF_TEST1,
               spcr_pkg::OFF_TIMERS};
        rv = '{32'h0080_6405, 32'h0, 32'h0, 32'h0, 32'h0000_6403, 32'h0, 32'h0034_B009,
               32'h0400_1060, 32'h0400_0800, 32'h8000_0000};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values of every register
        for (int i = 0; i < 10; i++) chk_rd(ra[i], rv[i]);
        `CHK(vga, 1'b1)
        `CHK({replay_lim, ack_lim}, {replay_b, ack_b})
        $display("test reset values done");
        // read-only fields, reserved bits, unmapped places
        wr(spcr_pkg::OFF_VEND_HDR, 32'hFFFF_FFFF);
        chk_rd(spcr_pkg::OFF_VEND_HDR, 32'h0034_B009);
        wr(spcr_pkg::OFF_MSI_DATA, 32'hFFFF_FFFF);
        chk_rd(spcr_pkg::OFF_MSI_DATA, 32'h0000_FFFF);
        chk_rd(8'h80, 32'h0);
        chk_rd(8'hFC, 32'h0);
        $display("test read-only done");
        // timer overrides, corners first then random, and random test words
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : rnd();
            wr(spcr_pkg::OFF_TIMERS, v);
            chk_rd(spcr_pkg::OFF_TIMERS, tmr_wr(v));
            `CHK(replay_lim, v[spcr_pkg::REPLAY_EN] ? v[11:0] : replay_b)
            `CHK(ack_lim, v[spcr_pkg::ACK_EN] ? v[29:16] : ack_b)
            v = rnd();
            wr(spcr_pkg::OFF_TEST0, v);
            chk_rd(spcr_pkg::OFF_TEST0, v);
            wr(spcr_pkg::OFF_TEST1, ~v);
            chk_rd(spcr_pkg::OFF_TEST1, ~v);
        end
        $display("test timers and test words done");
        // table writes at distinct addresses, reserved bits set in the command
        v = rnd();
        for (int i = 0; i < 8; i++) begin
            ta[i] = 6'(v[5:0] + 6'(i * 9));
            td[i] = rnd();
            wr(spcr_pkg::OFF_PD_WORD, td[i]);
            wr(spcr_pkg::OFF_PD_CTRL, {1'b1, 7'h7F, ta[i], 18'h3FFFF});
            chk_rd(spcr_pkg::OFF_PD_CTRL, pd_ctl(1'b1, ta[i]));
            wait_idle();
            chk_rd(spcr_pkg::OFF_PD_CTRL, pd_ctl(1'b0, ta[i]));
        end
        // table reads in reverse order, data register scribbled first
        for (int i = 7; i >= 0; i--) begin
            wr(spcr_pkg::OFF_PD_WORD, ~td[i]);
            wr(spcr_pkg::OFF_PD_CTRL, {1'b0, 7'h00, ta[i], 18'h0});
            chk_rd(spcr_pkg::OFF_PD_CTRL, pd_ctl(1'b0, ta[i]));
            wait_idle();
            chk_rd(spcr_pkg::OFF_PD_CTRL, pd_ctl(1'b1, ta[i]));
            chk_rd(spcr_pkg::OFF_PD_WORD, td[i]);
        end
        $display("test product data table done");
        // interrupt writes, blocked until enabled
        la = rnd();
        ua = rnd();
        md = rnd();
        wr(spcr_pkg::OFF_MSI_ADDR, la);
        wr(spcr_pkg::OFF_MSI_UPPER, ua);
        chk_rd(spcr_pkg::OFF_MSI_UPPER, ua);
        wr(spcr_pkg::OFF_MSI_DATA, md);
        chk_rd(spcr_pkg::OFF_MSI_ADDR, {la[31:2], 2'b00});
        msi_pulse(1'b0);
        wr(spcr_pkg::OFF_MSI_CTRL, 32'hFFFF_FFFF);
        chk_rd(spcr_pkg::OFF_MSI_CTRL, 32'h00F1_6405);
        msi_pulse(1'b1);
        #1;
        `CHK({msi_cnt, last_addr}, {16'h0001, ua, la[31:2], 2'b00})
        $display("test interrupt writes done");
        // default reload, interrupt disable included
        v = rnd() | 32'h0000_7000;
        @(posedge clk);
        def_timers <= v;
        def_load <= 1'b1;
        @(posedge clk);
        def_load <= 1'b0;
        chk_rd(spcr_pkg::OFF_TIMERS, tmr_def(v));
        `CHK({replay_lim, ack_lim}, {v[11:0], v[30] ? v[29:16] : ack_b})
        msi_pulse(1'b0);
        $display("test default reload done");
        summarize();
    end
endmodule
`default_nettype wire
